// ==== logic/pif_flags.sv ====
// pci interrupt flag registers with axi4-lite slave
`timescale 1ns/1ps
module pif_flags #(
   parameter int NSRC = 8
) (
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire pif_pkg::pif_axi_req_t axiReq,
   output      pif_pkg::pif_axi_rsp_t axiRsp,
   input  wire pif_pkg::pif_events_t  events,
   output      logic                  irq
);
   import pif_pkg::*;

   //---------------------------------------------------------------------------
   // elaboration check
   //---------------------------------------------------------------------------
   if (NSRC != PIF_NSRC)
   begin : g_bad_nsrc
      $error("pif_flags serves exactly eight sources");
   end

   //---------------------------------------------------------------------------
   // state
   //---------------------------------------------------------------------------
   typedef struct packed {
      logic [7:0]   enable;      // interrupt enable mask
      logic [7:0]   pending;     // sticky pending flags
      logic         awHeld;      // write address captured
      logic [31:0]  awAddr;
      logic         wHeld;       // write data captured
      logic [31:0]  wData;
      logic [3:0]   wStrb;
      logic         irq;
      pif_axi_rsp_t rsp;
   } pif_state_t;

   pif_state_t state_reg;
   pif_state_t state_next;

   //---------------------------------------------------------------------------
   // helpers
   //---------------------------------------------------------------------------
   // address decode, shared by read and write paths
   function automatic pif_sel_t pifDecode(input logic [31:0] addr);
      pif_sel_t sel;
      sel = PIF_SEL_NONE;
      case (addr)
         PIF_ENABLE_ADDR:  sel = PIF_SEL_ENABLE;
         PIF_PENDING_ADDR: sel = PIF_SEL_PENDING;
         PIF_FORCE_ADDR:   sel = PIF_SEL_FORCE;
         default:          sel = PIF_SEL_NONE;
      endcase
      return sel;
   endfunction : pifDecode

   // event pulses gathered onto the eight flag positions
   logic [7:0] eventSet;

   always_comb
   begin
      eventSet                = 8'h00;
      eventSet[PIF_BIT_DMAF]  = events.dmaDone;                               // see R09
      eventSet[PIF_BIT_IIER]  = events.iiBusyRequest | events.iiBoundary1k    // see R02
                              | events.iiMappedArea | events.iiTimeout        // see R03
                              | events.iiIfReset;
      eventSet[PIF_BIT_IFER]  = events.ifAddrParity | events.ifAbort;         // see R04
      eventSet[PIF_BIT_IPER]  = events.initDataParity;                        // see R05
      eventSet[PIF_BIT_TIER]  = events.tgtTimeout;                            // see R06
      eventSet[PIF_BIT_TBER]  = events.tgtByteEnable;                         // see R07
      eventSet[PIF_BIT_TPER]  = events.tgtDataParity;                         // see R08
      eventSet[PIF_BIT_SERR]  = events.serrSeen;                              // see R09
   end

   //---------------------------------------------------------------------------
   // next state
   //---------------------------------------------------------------------------
   // write decode and register update
   pif_sel_t   wrSel;
   pif_sel_t   rdSel;
   logic       doWrite;
   logic       lowLane;
   logic [7:0] wByte;
   logic       forceWrite;

   always_comb
   begin
      state_next = state_reg;
      wrSel      = pifDecode(state_reg.awAddr);
      rdSel      = pifDecode(axiReq.araddr);
      doWrite    = state_reg.awHeld && state_reg.wHeld && !state_reg.rsp.bvalid;
      lowLane    = state_reg.wStrb[0];
      wByte      = state_reg.wData[7:0];
      forceWrite = doWrite && lowLane && (wrSel == PIF_SEL_FORCE);

      // capture write address and data in either order
      if (axiReq.awvalid && state_reg.rsp.awready)
      begin
         state_next.awHeld      = 1'b1;
         state_next.awAddr      = axiReq.awaddr;
         state_next.rsp.awready = 1'b0;
      end
      if (axiReq.wvalid && state_reg.rsp.wready)
      begin
         state_next.wHeld      = 1'b1;
         state_next.wData      = axiReq.wdata;
         state_next.wStrb      = axiReq.wstrb;
         state_next.rsp.wready = 1'b0;
      end

      // perform the write once both halves are held
      if (doWrite)
      begin
         state_next.awHeld     = 1'b0;
         state_next.wHeld      = 1'b0;
         state_next.rsp.bvalid = 1'b1;
         state_next.rsp.bresp  = (wrSel == PIF_SEL_NONE) ? PIF_RESP_SLVERR : PIF_RESP_OKAY;
         if (lowLane)
         begin
            case (wrSel)
               PIF_SEL_ENABLE:
               begin
                  state_next.enable = wByte;                                  // see R01
               end
               PIF_SEL_PENDING:
               begin
                  state_next.pending = state_reg.pending & ~wByte;            // see R10
               end
               PIF_SEL_FORCE:
               begin
                  // upper bits follow the written value, serr only sets
                  state_next.pending = (wByte & PIF_FORCE_CLR_MASK)           // see R13
                                     | (state_reg.pending & ~PIF_FORCE_CLR_MASK)
                                     | wByte;                                 // see R14
               end
               default:
               begin
                  state_next.pending = state_reg.pending;
               end
            endcase
         end
      end

      // write answer taken, reopen both channels
      if (state_reg.rsp.bvalid && axiReq.bready)
      begin
         state_next.rsp.bvalid  = 1'b0;
         state_next.rsp.awready = 1'b1;
         state_next.rsp.wready  = 1'b1;
      end

      // hardware events win over any clear in the same cycle
      state_next.pending = state_next.pending | eventSet;

      // read path, one access at a time
      if (axiReq.arvalid && state_reg.rsp.arready)
      begin
         state_next.rsp.arready = 1'b0;
         state_next.rsp.rvalid  = 1'b1;
         state_next.rsp.rresp   = PIF_RESP_OKAY;
         state_next.rsp.rdata   = 32'h0000_0000;
         case (rdSel)
            PIF_SEL_ENABLE:  state_next.rsp.rdata[7:0] = state_reg.enable;
            PIF_SEL_PENDING: state_next.rsp.rdata[7:0] = state_reg.pending;
            PIF_SEL_FORCE:   state_next.rsp.rdata[7:0] = state_reg.pending;   // see R11
            default:         state_next.rsp.rresp      = PIF_RESP_SLVERR;
         endcase
      end
      else if (state_reg.rsp.rvalid && axiReq.rready)
      begin
         state_next.rsp.rvalid  = 1'b0;
         state_next.rsp.arready = 1'b1;
      end

      // level interrupt, plus a request on any force write with write strobe bit 0 set
      state_next.irq = (|(state_next.pending & state_next.enable))           // see R15
                     | forceWrite;                                           // see R12
   end

   //---------------------------------------------------------------------------
   // registers
   //---------------------------------------------------------------------------
   // all state in one flop bank
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_reg             <= '0;
         state_reg.enable      <= PIF_FLAG_RST;
         state_reg.pending     <= PIF_FLAG_RST;
         state_reg.rsp.awready <= 1'b1;
         state_reg.rsp.wready  <= 1'b1;
         state_reg.rsp.arready <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   //---------------------------------------------------------------------------
   // outputs
   //---------------------------------------------------------------------------
   // straight from the flop bank
   assign axiRsp = state_reg.rsp;
   assign irq    = state_reg.irq;

endmodule : pif_flags

// ==== logic/pif_pkg.sv ====
// constants, types and carriers for the pci interrupt flag block
//------------------------------------------------------------------------------
// Function
// R01 - one enable bit per source, bits 7..0
// R02 - initiator internal error sets pending bit 6
// R03 - five listed causes raise initiator internal error
// R04 - address parity or abort sets pending bit 5
// R05 - initiator data parity error sets bit 4
// R06 - target timeout sets pending bit 3
// R07 - unsupported target byte enables set bit 2
// R08 - target data parity error sets bit 1
// R09 - serr seen sets bit 0, dma done 7
// R10 - pending write one clears, zero keeps
// R11 - force reads back the pending contents
// R12 - force write itself raises the interrupt
// R13 - force zero clears pending bits 7..1
// R14 - force one sets; bit 0 zero ignored
// R15 - irq while any enabled pending bit set
//------------------------------------------------------------------------------
package pif_pkg;

   // register byte addresses
   localparam logic [31:0] PIF_ENABLE_ADDR  = 32'h8000_0164;
   localparam logic [31:0] PIF_PENDING_ADDR = 32'h8000_0168;
   localparam logic [31:0] PIF_FORCE_ADDR   = 32'h8000_016c;

   // field positions and widths
   localparam int          PIF_NSRC      = 8;
   localparam int          PIF_BIT_DMAF  = 7;
   localparam int          PIF_BIT_IIER  = 6;
   localparam int          PIF_BIT_IFER  = 5;
   localparam int          PIF_BIT_IPER  = 4;
   localparam int          PIF_BIT_TIER  = 3;
   localparam int          PIF_BIT_TBER  = 2;
   localparam int          PIF_BIT_TPER  = 1;
   localparam int          PIF_BIT_SERR  = 0;
   localparam logic [7:0]  PIF_FLAG_RST  = 8'h00;
   localparam logic [7:0]  PIF_FORCE_CLR_MASK = 8'hfe;

   // bus answers
   localparam logic [1:0]  PIF_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  PIF_RESP_SLVERR = 2'h2;

   // register select
   typedef enum logic [1:0] {PIF_SEL_NONE, PIF_SEL_ENABLE, PIF_SEL_PENDING, PIF_SEL_FORCE} pif_sel_t;

   // event pulses from the pci core, each one cycle high
   typedef struct packed {
      logic dmaDone;          // dma transfer finished
      logic iiBusyRequest;    // new request while dma active
      logic iiBoundary1k;     // dma hit 1 kb local boundary
      logic iiMappedArea;     // dma aimed at pci mapped area
      logic iiTimeout;        // initiator data timeout
      logic iiIfReset;        // interface reset during dma
      logic ifAddrParity;     // initiator address parity error
      logic ifAbort;          // initiator transaction abort
      logic initDataParity;   // initiator data parity error
      logic tgtTimeout;       // target data timeout
      logic tgtByteEnable;    // unsupported byte enables
      logic tgtDataParity;    // target data parity error
      logic serrSeen;         // serr observed on pci bus
   } pif_events_t;

   // axi4-lite master to slave
   typedef struct packed {
      logic        awvalid;
      logic [31:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [31:0] araddr;
      logic        rready;
   } pif_axi_req_t;

   // axi4-lite slave to master
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } pif_axi_rsp_t;

endpackage : pif_pkg

// ==== verif/pif_event_src.sv ====
// event source model standing in for the pci core
`timescale 1ns/1ps
module pif_event_src (
   input  wire logic                 clk,
   input  wire logic                 nrst,
   input  wire pif_pkg::pif_events_t fire,
   output      pif_pkg::pif_events_t events
);
   import pif_pkg::*;
   // one-cycle pulses launched from a flop
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         events <= '0;
      else
         events <= fire;
   end
endmodule : pif_event_src

// ==== verif/pif_flags_assertions.sv ====
// port assertions for the pci interrupt flag block
`timescale 1ns/1ps
module pif_flags_assertions #(
   parameter int NSRC = 8
) (
   input wire logic                  clk,
   input wire logic                  nrst,
   input wire pif_pkg::pif_axi_req_t axiReq,
   input wire pif_pkg::pif_axi_rsp_t axiRsp,
   input wire pif_pkg::pif_events_t  events,
   input wire logic                  irq
);
   import pif_pkg::*;
   logic wrTake;
   // write address and data taken together
   assign wrTake = axiReq.awvalid & axiRsp.awready & axiReq.wvalid & axiRsp.wready;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_write_answer: assert property (wrTake |-> ##2 axiRsp.bvalid) else $error("write answer late");
   a_ready_drop: assert property (wrTake |=> !axiRsp.awready && !axiRsp.wready) else $error("ready stayed");
   a_read_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid) else $error("read late");
   a_read_done: assert property (axiRsp.rvalid && axiReq.rready |=> !axiRsp.rvalid && axiRsp.arready)
      else $error("read not closed");
   a_read_upper: assert property (axiRsp.rvalid |-> axiRsp.rdata[31:8] == 24'h0)
      else $error("upper bits set");
   a_force_irq: assert property (wrTake && axiReq.awaddr == PIF_FORCE_ADDR && axiReq.wstrb[0] |-> ##2 irq)
      else $error("force gave no irq");
   a_irq_cause: assert property ($rose(irq) |-> $past(events) != '0 || axiRsp.bvalid)
      else $error("irq without cause");
   a_irq_drop: assert property ($fell(irq) |-> axiRsp.bvalid || $past(axiRsp.bvalid))
      else $error("irq fell without write");
endmodule : pif_flags_assertions
bind pif_flags pif_flags_assertions #(.NSRC(NSRC)) u_chk (.clk(clk), .nrst(nrst), .axiReq(axiReq),
   .axiRsp(axiRsp), .events(events), .irq(irq));

// ==== verif/test_pci_interrupt_flags.sv ====
// self-checking bench for the pci interrupt flag block
`timescale 1ns/1ps
module test_pci_interrupt_flags;
   import pif_pkg::*;
   logic         clk;
   logic         nrst;
   pif_axi_req_t req;
   pif_axi_rsp_t rsp;
   pif_events_t  fire;
   pif_events_t  events;
   logic         irq;
   logic [31:0]  rd;
   logic [1:0]   rs;
   logic [3:0]   wst;
   int           miscompares;
   int           n_checks;
   int           cycles;
   pif_flags #(.NSRC(8)) DUT (.clk(clk), .nrst(nrst), .axiReq(req), .axiRsp(rsp), .events(events), .irq(irq));
   pif_event_src u_src (.clk(clk), .nrst(nrst), .fire(fire), .events(events));
   // clock and hang guard
   always #20 clk = ~clk;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         miscompares++;
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   // axi write: address and data offered together, wait for response
   task automatic axw(input logic [31:0] a, input logic [31:0] d);
      req.awaddr <= a;
      req.wdata <= d;
      req.wstrb <= wst;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      do
      begin
         @(posedge clk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1);
      rs = rsp.bresp;
   endtask : axw
   task automatic axr(input logic [31:0] a);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      do
      begin
         @(posedge clk);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1);
      rd = rsp.rdata;
      rs = rsp.rresp;
   endtask : axr
   // one event pulse, then irq compared
   task automatic pulse(input int i, input logic e);
      fire <= pif_events_t'(13'h1 << i);
      @(posedge clk);
      fire <= '0;
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, {31'h0, e});
   endtask : pulse
   task automatic t_events();
      int b;
      axw(PIF_ENABLE_ADDR, 32'hff);
      for (int i = 0; i < 13; i++)
      begin
         b = (i == 12) ? 7 : (i > 6) ? 6 : (i > 4) ? 5 : i;
         pulse(i, 1'b1);
         axr(PIF_PENDING_ADDR);
         chk(rd, 32'h1 << b);
         axw(PIF_PENDING_ADDR, 32'h1 << b);
         chk({31'h0, irq}, 32'h0);
      end
      $display("events test done");
   endtask : t_events
   task automatic t_mask();
      axw(PIF_ENABLE_ADDR, 32'h0);
      pulse(12, 1'b0);
      axw(PIF_PENDING_ADDR, 32'h0);
      axr(PIF_PENDING_ADDR);
      chk(rd, 32'h80);
      axw(PIF_ENABLE_ADDR, 32'h80);
      chk({31'h0, irq}, 32'h1);
      // event lands in the cycle of the clear: the event stays
      fire <= pif_events_t'(13'h1 << 12);
      fork
         axw(PIF_PENDING_ADDR, 32'h80);
         begin
            @(posedge clk);
            fire <= '0;
         end
      join
      chk({31'h0, irq}, 32'h1);
      axr(PIF_PENDING_ADDR);
      chk(rd, 32'h80);
      axw(PIF_PENDING_ADDR, 32'h80);
      chk({31'h0, irq}, 32'h0);
      $display("mask test done");
   endtask : t_mask
   task automatic t_force();
      axw(PIF_ENABLE_ADDR, 32'h0);
      axw(PIF_FORCE_ADDR, 32'ha5);
      chk({31'h0, irq}, 32'h1);
      axr(PIF_FORCE_ADDR);
      chk(rd, 32'ha5);
      axw(PIF_FORCE_ADDR, 32'h0);
      axr(PIF_PENDING_ADDR);
      chk(rd, 32'h01);
      axw(PIF_PENDING_ADDR, 32'h01);
      // low byte lane off: no update and no force pulse
      wst = 4'h0;
      axw(PIF_FORCE_ADDR, 32'hff);
      chk({31'h0, irq}, 32'h0);
      chk({30'h0, rs}, {30'h0, PIF_RESP_OKAY});
      wst = 4'hf;
      axr(PIF_PENDING_ADDR);
      chk(rd, 32'h0);
      axw(32'h8000_0170, 32'hff);
      chk({30'h0, rs}, {30'h0, PIF_RESP_SLVERR});
      axr(32'h8000_0170);
      chk({30'h0, rs}, {30'h0, PIF_RESP_SLVERR});
      axr(PIF_PENDING_ADDR);
      chk(rd, 32'h0);
      $display("force test done");
   endtask : t_force
   // reset, then the scenarios
   initial
   begin
      clk = 1'b0;
      nrst = 1'b0;
      req = '0;
      req.bready = 1'b1;
      req.rready = 1'b1;
      fire = '0;
      wst = 4'hf;
      miscompares = 0;
      n_checks = 0;
      cycles = 0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      axr(PIF_ENABLE_ADDR);
      chk(rd, 32'h0);
      chk({30'h0, rs}, {30'h0, PIF_RESP_OKAY});
      t_events();
      t_mask();
      t_force();
      wrap_up();
   end
endmodule : test_pci_interrupt_flags
